// *** plh_defs.svh ***
// Purpose: constants for the launch handshake block
// Assumes: 250 MHz sys_clk
// Notes: offsets, fields, reset values and timing counts
`ifndef PLH_DEFS_SVH
`define PLH_DEFS_SVH
`define PLH_CLK_MHZ 250
`define PLH_ADDR_W 4
`define PLH_OFF_CTRL 4'h0
`define PLH_OFF_STAT 4'h4
`define PLH_OFF_IRQ 4'h8
`define PLH_OFF_MASK 4'hC
`define PLH_CTRL_TRIG_EN 0
`define PLH_CTRL_DONE 1
`define PLH_CTRL_RESULT 2
`define PLH_STAT_ACTIVE 0
`define PLH_STAT_BUSY 1
`define PLH_STAT_PASS 2
`define PLH_STAT_FAIL 3
`define PLH_IRQ_LAUNCH 0
`define PLH_IRQ_DONE 1
`define PLH_IRQ_DROP 2
`define PLH_IRQ_W 3
`define PLH_TRIG_EN_RST 1'b0
`define PLH_STEP_NS 8
`define PLH_STEP_CYC ((`PLH_STEP_NS * `PLH_CLK_MHZ + 999) / 1000)
`endif

// *** plh_pkg.sv ***
// Purpose: types for the launch handshake block
// Assumes: nothing beyond the defs header
// Notes: Gray coded run states
package plh_pkg;
  typedef enum logic [1:0] {
    PLH_IDLE = 2'b00,
    PLH_CLEAR = 2'b01,
    PLH_BUSY = 2'b11,
    PLH_SHOW = 2'b10
  } plh_state_t;
endpackage

// *** plh_sync_if.sv ***
// Purpose: carries synchronised pin levels into the core
// Assumes: single sys_clk domain
// Notes: plain levels, no handshake
interface plh_sync_if;
  logic start_n;
  logic sense_n;
  logic io_supply_ref;
  modport src (output start_n, output sense_n, output io_supply_ref);
  modport dst (input start_n, input sense_n, input io_supply_ref);
endinterface

// *** plh_sync.sv ***
// Purpose: two-flop synchronisers for the port pins
// Assumes: pins asynchronous to sys_clk
// Notes: first stage read only by the second stage
module plh_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [2:0] pins,
  plh_sync_if.src sync
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } plh_sync_st_t;
  plh_sync_st_t st;
  plh_sync_st_t next_st;

  // Pull-ups idle start and sense high, so reset those high; supply resets low
  always_comb begin
    next_st.meta = pins;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= {3'h6, 3'h6};
    end else begin
      st <= next_st;
    end
  end

  // Bit 0 supply, bit 1 start, bit 2 sense
  assign sync.io_supply_ref = st.stable[0];
  assign sync.start_n = st.stable[1];
  assign sync.sense_n = st.stable[2];
endmodule

// *** plh_top.sv ***
// Purpose: launch request and pass, fail, ready handshake of the control port
// Assumes: firmware runs programming and reports completion via the control register
// Notes: outputs are open-drain style: data plus enable, enabled only with supply
//
// Functional notes
// [R1] Launch only when enabled and port active
// [R2] Active means supply present and presence low
// [R3] Trigger enable held until rewritten
// [R4] Enable one permits, zero forbids launching
// [R5] Ready output low while idle
// [R6] Edge: pass/fail high, then ready high
// [R7] Done: pass/fail set, then ready low
// [R8] Falling edge captured in hardware
// [R9] Edge controller waits for ready falling edge
// [R10] Polling controller waits then polls ready
// [R11] Pass low only after successful run
// [R12] Fail low only after failed run
// [R13] Ready low idle, high busy
// [R14] Outputs driven only with supply present
// [R15] Unaccepted launch edges are dropped
`include "plh_defs.svh"
module plh_top
  import plh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start_in_n,
  input wire logic sense_in_n,
  input wire logic io_supply_ref,
  input wire logic [`PLH_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic pass_out_n,
  output logic pass_oe,
  output logic fail_out_n,
  output logic fail_oe,
  output logic ready_out_n,
  output logic ready_oe,
  output logic irq
);
  import plh_pkg::*;

  localparam int STEP = `PLH_STEP_CYC;

  typedef struct packed {
    plh_state_t state;
    logic [7:0] step_cnt;
    logic start_prev;
    logic trig_en;
    logic done_pend;
    logic done_result;
    logic [`PLH_IRQ_W-1:0] irq_stat;
    logic [`PLH_IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic pass_n;
    logic fail_n;
    logic ready_n;
    logic oe;
    logic irq;
  } plh_st_t;

  plh_st_t st;
  plh_st_t next_st;
  plh_sync_if sync ();

  logic port_active;
  logic fall_edge;
  logic accept;
  logic [`PLH_IRQ_W-1:0] ev;

  plh_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pins({sense_in_n, start_in_n, io_supply_ref}),
    .sync(sync)
  );

  // Port activity and launch qualification
  assign port_active = sync.io_supply_ref && !sync.sense_n; // R2
  assign fall_edge = st.start_prev && !sync.start_n; // R8
  assign accept = fall_edge && st.trig_en && port_active && (st.state == PLH_IDLE); // R1 R4
  assign ev[`PLH_IRQ_LAUNCH] = accept;
  assign ev[`PLH_IRQ_DONE] = (st.state == PLH_SHOW) && (st.step_cnt == 8'h00);
  assign ev[`PLH_IRQ_DROP] = fall_edge && !accept; // R15

  // Next-state logic for handshake, registers and interrupt
  always_comb begin
    next_st = st;
    next_st.start_prev = sync.start_n;
    next_st.oe = sync.io_supply_ref; // R14
    if (st.step_cnt != 8'h00) begin
      next_st.step_cnt = st.step_cnt - 8'h01;
    end
    case (st.state)
      PLH_IDLE: begin
        next_st.ready_n = 1'b0; // R5 R13
        if (accept) begin
          // Clear result first; ready rises only after a settle step
          next_st.pass_n = 1'b1; // R6 R11 R12
          next_st.fail_n = 1'b1;
          next_st.step_cnt = STEP[7:0];
          next_st.done_pend = 1'b0;
          next_st.state = PLH_CLEAR;
        end
      end
      PLH_CLEAR: begin
        if (st.step_cnt == 8'h00) begin
          next_st.ready_n = 1'b1; // R6 R13
          next_st.state = PLH_BUSY;
        end
      end
      PLH_BUSY: begin
        if (st.done_pend) begin
          // Result lands before ready falls, so a ready edge means valid result
          next_st.pass_n = !st.done_result; // R7 R11
          next_st.fail_n = st.done_result; // R7 R12
          next_st.done_pend = 1'b0;
          next_st.step_cnt = STEP[7:0];
          next_st.state = PLH_SHOW;
        end
      end
      PLH_SHOW: begin
        if (st.step_cnt == 8'h00) begin
          next_st.ready_n = 1'b0; // R7
          next_st.state = PLH_IDLE;
        end
      end
      default: begin
        next_st.state = PLH_IDLE;
      end
    endcase

    // Register writes; enable bit persists until rewritten
    if (reg_wr) begin
      case (reg_addr)
        `PLH_OFF_CTRL: begin
          next_st.trig_en = reg_wdata[`PLH_CTRL_TRIG_EN]; // R3 R4
          if (reg_wdata[`PLH_CTRL_DONE] && st.state == PLH_BUSY) begin
            next_st.done_pend = 1'b1;
            next_st.done_result = reg_wdata[`PLH_CTRL_RESULT];
          end
        end
        `PLH_OFF_MASK: next_st.irq_mask = reg_wdata[`PLH_IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // Reads answer next cycle; unmapped reads return zero
    next_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `PLH_OFF_CTRL: next_st.rdata[`PLH_CTRL_TRIG_EN] = st.trig_en;
        `PLH_OFF_STAT: begin
          next_st.rdata[`PLH_STAT_ACTIVE] = port_active;
          next_st.rdata[`PLH_STAT_BUSY] = st.ready_n;
          next_st.rdata[`PLH_STAT_PASS] = !st.pass_n;
          next_st.rdata[`PLH_STAT_FAIL] = !st.fail_n;
        end
        `PLH_OFF_IRQ: next_st.rdata[`PLH_IRQ_W-1:0] = st.irq_stat;
        `PLH_OFF_MASK: next_st.rdata[`PLH_IRQ_W-1:0] = st.irq_mask;
        default: begin
        end
      endcase
    end

    // Read clears status, but an event in the same cycle still sets
    if (reg_rd && reg_addr == `PLH_OFF_IRQ) begin
      next_st.irq_stat = ev;
    end else begin
      next_st.irq_stat = st.irq_stat | ev;
    end
    next_st.irq = |(next_st.irq_stat & st.irq_mask);
  end

  // State register; volatile here, persistence is the enable source's job
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{state: PLH_IDLE, step_cnt: 8'h00, start_prev: 1'b1,
              trig_en: `PLH_TRIG_EN_RST, done_pend: 1'b0, done_result: 1'b0,
              irq_stat: 3'h0, irq_mask: 3'h0, rdata: 32'h0000_0000,
              pass_n: 1'b1, fail_n: 1'b1, ready_n: 1'b0, oe: 1'b0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pass_out_n = st.pass_n;
  assign fail_out_n = st.fail_n;
  assign ready_out_n = st.ready_n;
  assign pass_oe = st.oe;
  assign fail_oe = st.oe;
  assign ready_oe = st.oe;
  assign irq = st.irq;

  // Ready rises only after pass and fail are both high
  a_busy_after_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(st.ready_n) |-> (st.pass_n && st.fail_n && $past(st.pass_n) && $past(st.fail_n)))
    else $error("ready rose before result cleared"); // R6

  // Ready falls only after result stood for at least one cycle
  a_result_before_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(st.ready_n) |-> ($past(st.pass_n) != $past(st.fail_n)))
    else $error("ready fell without a result"); // R7

  // Accepted edge moves out of idle next cycle
  a_launch_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept |=> (st.state == PLH_CLEAR) ##[1:4] st.ready_n)
    else $error("accepted launch not started"); // R1

  // No launch without enable or activity
  a_launch_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st.state == PLH_IDLE && !(st.trig_en && port_active)) |=> st.state == PLH_IDLE)
    else $error("launch while gated"); // R1 R2 R4

  // Dropped edge is not queued
  a_drop_no_queue: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st.state == PLH_BUSY && fall_edge) |=> !accept)
    else $error("edge queued during run"); // R15

  // Idle implies ready low
  a_idle_ready_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st.state == PLH_IDLE && $past(st.state) == PLH_IDLE) |-> !st.ready_n)
    else $error("ready high while idle"); // R5 R13

  // Pass and fail never both low
  a_result_exclusive: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(!st.pass_n && !st.fail_n))
    else $error("pass and fail both low"); // R11 R12

  // Enables follow synchronised supply one cycle later
  a_oe_supply: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 (pass_oe == $past(sync.io_supply_ref)))
    else $error("output enable wrong"); // R14

  // Falling synced start is seen as an edge
  a_edge_caught: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(sync.start_n) && !sync.start_n) |-> fall_edge)
    else $error("start edge missed"); // R8

  // Enable bit holds without a write
  a_enable_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(reg_wr) |-> $stable(st.trig_en))
    else $error("enable changed without write"); // R3

  // A run starts only from a fresh edge, never from a remembered one
  a_fresh_edge_only: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    (st.state == PLH_IDLE && !fall_edge) |=> (st.state != PLH_CLEAR))
    else $error("launch without a new edge");

  // Settle step keeps result cleared and ready still low
  a_clear_result_high: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    (st.state == PLH_CLEAR) |-> (st.pass_n && st.fail_n && !st.ready_n))
    else $error("clear step outputs wrong");

  // While running, busy shown and no result reported
  a_busy_ready_high: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    (st.state == PLH_BUSY) |-> (st.ready_n && st.pass_n && st.fail_n))
    else $error("busy outputs wrong");

  // Result stands while ready is still high
  a_show_result_set: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    (st.state == PLH_SHOW) |-> (st.ready_n && (st.pass_n != st.fail_n)))
    else $error("result not set before idle");

  // Ready rises only out of the settle step
  a_rise_from_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    $rose(st.ready_n) |-> ($past(st.state) == PLH_CLEAR))
    else $error("ready rose outside settle step");

  // Ready falls only out of the result step
  a_fall_from_show: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    $fell(st.ready_n) |-> ($past(st.state) == PLH_SHOW))
    else $error("ready fell outside result step");

  // Launch needed enable, supply and presence one cycle before
  a_start_qualified: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1 R2 R4
    (st.state == PLH_CLEAR && $past(st.state) == PLH_IDLE) |->
      ($past(st.trig_en) && $past(sync.io_supply_ref) && !$past(sync.sense_n)))
    else $error("launch without enable or activity");

  // Accepted launch clears any old result
  a_accept_clears: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11 R12
    accept |=> (st.pass_n && st.fail_n))
    else $error("old result kept after launch");

  // Idle without launch keeps the last result
  a_idle_result_holds: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11 R12
    (st.state == PLH_IDLE && !accept) |=> ($stable(st.pass_n) && $stable(st.fail_n)))
    else $error("result changed while idle");

  // Settle counter never exceeds its load value
  a_step_bounded: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st.step_cnt <= STEP[7:0])
    else $error("settle counter out of range");

  // No interrupt without a pending status bit
  a_irq_needs_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st.irq_stat == '0) |-> !st.irq)
    else $error("interrupt without status");

  // Read data bus idles at zero outside the answer cycle
  a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(reg_rd) |-> (st.rdata == 32'h0000_0000))
    else $error("read data not zero when idle");
endmodule

// *** plh_ctl_model.sv ***
// Purpose: model of the external controller that drives the launch pins
// Assumes: lines are pulled up, so idle start and sense read high
// Notes: only the edge-driven method; the polled 100mS wait would swamp the run
module plh_ctl_model (
  input wire logic sys_clk,
  input wire logic ready_pin_n,
  output logic start_n,
  output logic sense_n,
  output logic supply
);
  // Pull-ups idle high, supply absent until powered
  initial begin
    start_n = 1'b1;
    sense_n = 1'b1;
    supply = 1'b0;
  end

  // Port power and presence, changed just after an edge
  task automatic set_port(input logic pwr, input logic present);
    @(posedge sys_clk);
    supply <= pwr;
    sense_n <= ~present;
  endtask

  // Low pulse on the launch line; waits for idle first unless told not to
  task automatic launch(input int low_cyc, input logic wait_idle);
    int n;
    n = 0;
    while (wait_idle && ready_pin_n !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    start_n <= 1'b0;
    repeat (low_cyc) @(posedge sys_clk);
    start_n <= 1'b1;
  endtask
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the launch handshake block
// Assumes: outputs pulled high on the board while not enabled
// Notes: firmware role played by register writes of done and result
`include "plh_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [`PLH_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic pass_out_n, pass_oe, fail_out_n, fail_oe, ready_out_n, ready_oe, irq;
  logic start_n, sense_n, supply;
  logic pass_pin, fail_pin, ready_pin;
  int fails = 0;
  int compares = 0;

  // Pull-ups win whenever an output is not enabled
  assign pass_pin = pass_oe ? pass_out_n : 1'b1;
  assign fail_pin = fail_oe ? fail_out_n : 1'b1;
  assign ready_pin = ready_oe ? ready_out_n : 1'b1;

  plh_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .start_in_n(start_n),
    .sense_in_n(sense_n), .io_supply_ref(supply), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pass_out_n(pass_out_n), .pass_oe(pass_oe), .fail_out_n(fail_out_n),
    .fail_oe(fail_oe), .ready_out_n(ready_out_n), .ready_oe(ready_oe), .irq(irq));

  plh_ctl_model ctl (.sys_clk(sys_clk), .ready_pin_n(ready_pin), .start_n(start_n),
    .sense_n(sense_n), .supply(supply));

  // 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Bounded wait for the ready pin to reach a level
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (ready_pin !== lvl && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check(ready_pin, lvl);
  endtask

  task automatic t_reset;
    check({pass_oe, fail_oe, ready_oe}, 3'b000);
    check({pass_out_n, fail_out_n, ready_out_n}, 3'b110);
    reg_read(`PLH_OFF_CTRL);
    check(rd[0], `PLH_TRIG_EN_RST);
    $display("test reset done");
  endtask

  // Launches refused while disabled or while presence is missing
  task automatic t_drop;
    ctl.set_port(1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    #1 check({pass_oe, fail_oe, ready_oe}, 3'b111);
    check(ready_pin, 1'b0);
    reg_read(`PLH_OFF_STAT);
    check(rd[0], 1'b1);
    reg_write(`PLH_OFF_MASK, 32'h7);
    reg_read(`PLH_OFF_MASK);
    check(rd, 32'h7);
    ctl.launch(2, 1'b1);
    repeat (12) @(posedge sys_clk);
    #1 check(ready_pin, 1'b0);
    check(irq, 1'b1);
    reg_read(`PLH_OFF_IRQ);
    check(rd, 32'h4);
    @(posedge sys_clk);
    #1 check(irq, 1'b0);
    ctl.set_port(1'b1, 1'b0);
    reg_write(`PLH_OFF_CTRL, 32'h1);
    reg_read(`PLH_OFF_STAT);
    check(rd[0], 1'b0);
    ctl.launch(2, 1'b1);
    repeat (12) @(posedge sys_clk);
    #1 check(ready_pin, 1'b0);
    reg_read(`PLH_OFF_IRQ);
    check(rd, 32'h4);
    ctl.set_port(1'b1, 1'b1);
    $display("test drop done");
  endtask

  // One-cycle launch pulse, a second launch while busy, then finish
  task automatic t_run(input logic ok);
    reg_write(`PLH_OFF_CTRL, 32'h1);
    ctl.launch(1, 1'b1);
    wait_ready(1'b1);
    check({pass_pin, fail_pin}, 2'b11);
    reg_read(`PLH_OFF_STAT);
    check(rd[1], 1'b1);
    ctl.launch(2, 1'b0);
    repeat (8) @(posedge sys_clk);
    reg_write(`PLH_OFF_CTRL, {29'h0, ok, 2'b11});
    wait_ready(1'b0);
    check({pass_pin, fail_pin}, {~ok, ok});
    check(irq, 1'b1);
    reg_read(`PLH_OFF_IRQ);
    check(rd, 32'h7);
    reg_read(`PLH_OFF_STAT);
    check(rd[3:0], {~ok, ok, 1'b0, 1'b1});
    reg_read(`PLH_OFF_CTRL);
    check(rd[0], 1'b1);
    $display("test run %0d done", ok);
  endtask

  task automatic t_unpower;
    ctl.set_port(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    #1 check({pass_oe, fail_oe, ready_oe}, 3'b000);
    $display("test unpower done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 t_reset();
    t_drop();
    t_run(1'b1);
    t_run(1'b0);
    t_unpower();
    report_and_stop();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 4);
    fails++;
    report_and_stop();
  end
endmodule
